// file: hw/tco_pkg.sv
// Shared constants and types for the timer channel output stage
package tco_pkg;
    localparam int TCO_NCH = 8;
    localparam int TCO_AW  = 8;
    localparam int TCO_DW  = 32;

    typedef logic [TCO_NCH-1:0] tco_chan_vec_t;
    typedef logic [TCO_AW-1:0]  tco_addr_t;
    typedef logic [TCO_DW-1:0]  tco_word_t;

    // Register byte offsets
    localparam tco_addr_t TCO_OFS_LEVEL  = 8'h00;
    localparam tco_addr_t TCO_OFS_ENABLE = 8'h04;
    localparam tco_addr_t TCO_OFS_POL    = 8'h08;
    localparam tco_addr_t TCO_OFS_MODE   = 8'h0C;
    localparam tco_addr_t TCO_OFS_STSEL  = 8'h10;
    localparam tco_addr_t TCO_OFS_ISTAT  = 8'h14;
    localparam tco_addr_t TCO_OFS_IMASK  = 8'h18;

    // Reset values
    localparam tco_chan_vec_t TCO_VEC_RST = 8'h00;
    localparam logic          TCO_BIT_RST = 1'b0;
    localparam tco_word_t     TCO_WORD_ZERO = 32'h0000_0000;
    localparam logic [TCO_DW-TCO_NCH-1:0] TCO_PAD_ZERO = 24'h00_0000;

    // Output mode bit values
    localparam logic TCO_MODE_MASTER = 1'b0;
    localparam logic TCO_MODE_SLAVE  = 1'b1;

    // Per-channel configuration held by software
    typedef struct packed {
        tco_chan_vec_t sel;
        tco_chan_vec_t mode;
        tco_chan_vec_t pol;
        tco_chan_vec_t en;
    } tco_cfg_t;

    localparam tco_cfg_t TCO_CFG_RST = '{
        sel: TCO_VEC_RST, mode: TCO_VEC_RST,
        pol: TCO_VEC_RST, en: TCO_VEC_RST};
endpackage

// file: hw/tco_chan_latch.sv
// Output latch of one timer channel with set/reset/toggle logic
`timescale 1ns/100ps
module tco_chan_latch (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Channel settings
    input  wire logic out_en,
    input  wire logic out_mode,
    input  wire logic out_pol,
    // Timer events
    input  wire logic own_ev,
    input  wire logic master_ev,
    input  wire logic count_tick,
    // Software write
    input  wire logic sw_we,
    input  wire logic sw_val,
    // Pin latch
    output logic      level
);
    import tco_pkg::*;

    logic level_q;
    logic level_d;
    logic pend_q;
    logic pend_d;
    logic fire;
    logic set_now;
    logic rst_now;
    logic tgl_now;

    // Decode events; polarity is only looked at when an event lands
    always_comb begin
        fire    = pend_q & count_tick;
        pend_d  = pend_q;
        set_now = 1'b0;
        rst_now = 1'b0;
        tgl_now = 1'b0;
        if (!out_en) begin
            pend_d = TCO_BIT_RST;                 // RULE6
        end else if (out_mode == TCO_MODE_MASTER) begin
            tgl_now = own_ev;                     // RULE1
            pend_d  = TCO_BIT_RST;
        end else begin
            // Master edge held one count clock, so 0%/100% duty works
            pend_d = master_ev | (pend_q & ~count_tick); // RULE11
            if (!out_pol) begin                   // RULE2
                set_now = fire;                   // RULE3
                rst_now = own_ev;
            end else begin
                set_now = own_ev;                 // RULE3
                rst_now = fire;
            end
        end
        // Latch update: software only while disabled, reset beats set
        level_d = level_q;                        // RULE5
        if (!out_en) begin
            if (sw_we) begin
                level_d = sw_val;                 // RULE6
            end
        end else if (rst_now) begin
            level_d = 1'b0;                       // RULE4
        end else if (set_now) begin
            level_d = 1'b1;
        end else if (tgl_now) begin
            level_d = ~level_q;                   // RULE1
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_q <= TCO_BIT_RST;               // RULE18
            pend_q  <= TCO_BIT_RST;
        end else begin
            level_q <= level_d;
            pend_q  <= pend_d;
        end
    end

    assign level = level_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_toggle;
        out_en && !out_mode && own_ev |=> level == !$past(level);
    endproperty
    a_toggle: assert property (p_toggle) // RULE1
        else $error("master mode event did not toggle");

    property p_rst_wins;
        out_en && out_mode && rst_now |=> !level;
    endproperty
    a_rst_wins: assert property (p_rst_wins) // RULE4
        else $error("reset did not win");

    property p_set_late;
        out_en && out_mode && !out_pol && master_ev && !own_ev
            && !pend_q && !level |=> !level;
    endproperty
    a_set_late: assert property (p_set_late) // RULE11
        else $error("master set not delayed");

    property p_locked;
        out_en && !own_ev && !fire |=> $stable(level);
    endproperty
    a_locked: assert property (p_locked) // RULE5
        else $error("enabled output moved without event");

    property p_pol_change;
        $changed(out_pol) && out_en && !own_ev && !fire
            |=> $stable(level);
    endproperty
    a_pol_change: assert property (p_pol_change) // RULE10
        else $error("polarity change moved the pin");

    property p_sw_write;
        !out_en && sw_we |=> level == $past(sw_val);
    endproperty
    a_sw_write: assert property (p_sw_write) // RULE6
        else $error("software write not taken");

    property p_blocked;
        !out_en && !sw_we |=> $stable(level);
    endproperty
    a_blocked: assert property (p_blocked) // RULE6
        else $error("disabled output moved by event");

    property p_zero_duty;
        out_en && out_mode && fire && own_ev;
    endproperty
    c_zero_duty: cover property (p_zero_duty);
endmodule // tco_chan_latch

// file: hw/tco_output_ctrl.sv
// Timer unit channel output stage: eight pin latches behind APB
// Behaviour
// RULE1: Master mode toggles latch on own interrupt
// RULE2: Slave mode uses master and own interrupts
// RULE3: Polarity picks which interrupt sets or resets
// RULE4: Simultaneous set and reset: reset wins
// RULE5: Enabled channel ignores software output writes
// RULE6: Disabled channel takes writes, blocks interrupts
// RULE7: Output register always readable, shows pin levels
// RULE8: Software sets mode, level, enable, then starts
// RULE9: Output settings never touch counter or reload
// RULE10: Polarity change waits for next set/reset
// RULE11: Master set on slave delayed one count
// RULE12: One write updates only disabled channels
// RULE13: Start interrupt and toggle when select set
// RULE14: Other modes give nothing at count start
// RULE15: Eight channels, even ones may be masters
// RULE16: Software avoids changes near timer interrupts
// RULE17: Interval use gives 50% square wave
// RULE18: Reset clears latches and settings; synchronous
`timescale 1ns/100ps
module tco_output_ctrl (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire tco_pkg::tco_addr_t     paddr,
    input  wire tco_pkg::tco_word_t     pwdata,
    output logic                        pready,
    output tco_pkg::tco_word_t          prdata,
    output logic                        pslverr,
    // Counter channel events
    input  wire tco_pkg::tco_chan_vec_t chan_cycle_end,
    input  wire tco_pkg::tco_chan_vec_t chan_start_trigger,
    input  wire tco_pkg::tco_chan_vec_t chan_intcap_mode,
    input  wire logic                   count_tick,
    // Timer interrupts and pins
    output tco_pkg::tco_chan_vec_t      master_tick_irq,
    output tco_pkg::tco_chan_vec_t      chan_out_bit,
    output logic                        irq
);
    import tco_pkg::*;

    tco_cfg_t      cfg_q;
    tco_cfg_t      cfg_d;
    tco_chan_vec_t tick_q;
    tco_chan_vec_t tick_d;
    tco_chan_vec_t istat_q;
    tco_chan_vec_t istat_d;
    tco_chan_vec_t imask_q;
    tco_chan_vec_t imask_d;
    tco_word_t     prdata_q;
    tco_word_t     prdata_d;
    tco_chan_vec_t level;
    tco_chan_vec_t master_ev;
    tco_chan_vec_t wbyte;
    logic          access;
    logic          wr;
    logic          rd_setup;
    logic          hit;
    logic          wr_level;
    logic          wr_enable;
    logic          wr_pol;
    logic          wr_mode;
    logic          wr_stsel;
    logic          wr_istat;
    logic          wr_imask;

    // APB handshake: zero wait states, answer in the access cycle
    assign access = psel & penable;
    assign wr     = access & pwrite;
    assign wbyte  = pwdata[TCO_NCH-1:0];
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    // Address decode
    always_comb begin
        hit       = 1'b1;
        wr_level  = 1'b0;
        wr_enable = 1'b0;
        wr_pol    = 1'b0;
        wr_mode   = 1'b0;
        wr_stsel  = 1'b0;
        wr_istat  = 1'b0;
        wr_imask  = 1'b0;
        if (paddr == TCO_OFS_LEVEL) begin
            wr_level = wr;
        end else if (paddr == TCO_OFS_ENABLE) begin
            wr_enable = wr;
        end else if (paddr == TCO_OFS_POL) begin
            wr_pol = wr;
        end else if (paddr == TCO_OFS_MODE) begin
            wr_mode = wr;
        end else if (paddr == TCO_OFS_STSEL) begin
            wr_stsel = wr;
        end else if (paddr == TCO_OFS_ISTAT) begin
            wr_istat = wr;
        end else if (paddr == TCO_OFS_IMASK) begin
            wr_imask = wr;
        end else begin
            hit = 1'b0;
        end
    end

    // Unmapped addresses answer with an error, reads give zero
    assign pslverr = access & ~hit;

    // Read mux, captured in setup so prdata leaves a flip-flop;
    // the price is that pin levels read one cycle old
    always_comb begin
        prdata_d = TCO_WORD_ZERO;
        if (!rd_setup) begin
            prdata_d = TCO_WORD_ZERO;
        end else if (paddr == TCO_OFS_LEVEL) begin
            prdata_d = {TCO_PAD_ZERO, level};        // RULE7
        end else if (paddr == TCO_OFS_ENABLE) begin
            prdata_d = {TCO_PAD_ZERO, cfg_q.en};
        end else if (paddr == TCO_OFS_POL) begin
            prdata_d = {TCO_PAD_ZERO, cfg_q.pol};
        end else if (paddr == TCO_OFS_MODE) begin
            prdata_d = {TCO_PAD_ZERO, cfg_q.mode};
        end else if (paddr == TCO_OFS_STSEL) begin
            prdata_d = {TCO_PAD_ZERO, cfg_q.sel};
        end else if (paddr == TCO_OFS_ISTAT) begin
            prdata_d = {TCO_PAD_ZERO, istat_q};
        end else if (paddr == TCO_OFS_IMASK) begin
            prdata_d = {TCO_PAD_ZERO, imask_q};
        end
    end

    // Settings; these feed the latches and the start interrupt select, never the counters
    always_comb begin
        cfg_d = cfg_q;                               // RULE9
        if (wr_enable) begin
            cfg_d.en = wbyte;
        end
        if (wr_pol) begin
            cfg_d.pol = wbyte;                       // RULE10
        end
        if (wr_mode) begin
            cfg_d.mode = wbyte;
        end
        if (wr_stsel) begin
            cfg_d.sel = wbyte;
        end
    end

    // Timer interrupt: cycle end, or count start when selected
    always_comb begin
        tick_d = chan_cycle_end
               | (chan_start_trigger & chan_intcap_mode
                  & cfg_q.sel);                      // RULE13 RULE14
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_comb begin
        istat_d = istat_q;
        if (wr_istat) begin
            istat_d = istat_q & ~wbyte;
        end
        istat_d = istat_d | tick_q;
        imask_d = wr_imask ? wbyte : imask_q;
    end

    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_q   <= TCO_CFG_RST;                  // RULE18
            tick_q  <= TCO_VEC_RST;
            istat_q <= TCO_VEC_RST;
            imask_q <= TCO_VEC_RST;
            prdata_q <= TCO_WORD_ZERO;
        end else begin
            cfg_q   <= cfg_d;
            tick_q  <= tick_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            prdata_q <= prdata_d;
        end
    end

    assign master_tick_irq = tick_q;
    assign prdata          = prdata_q;
    assign irq             = |(istat_q & imask_q);
    assign chan_out_bit    = level;

    // One latch per channel; a slave follows the even channel below
    genvar gi;
    generate
        for (gi = 0; gi < TCO_NCH; gi++) begin : g_ch
            localparam int MI = (gi % 2 == 1) ? gi - 1
                              : ((gi >= 2) ? gi - 2 : 0);
            if (gi == 0) begin : g_nomaster
                assign master_ev[gi] = 1'b0;
            end else begin : g_master
                assign master_ev[gi] = tick_q[MI];   // RULE15
            end
            tco_chan_latch u_latch (
                .clock      (clock),
                .sys_rst    (sys_rst),
                .out_en     (cfg_q.en[gi]),
                .out_mode   (cfg_q.mode[gi]),
                .out_pol    (cfg_q.pol[gi]),
                .own_ev     (tick_q[gi]),            // RULE17
                .master_ev  (master_ev[gi]),
                .count_tick (count_tick),
                .sw_we      (wr_level),              // RULE12
                .sw_val     (wbyte[gi]),
                .level      (level[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_read_level;
        access && !pwrite && paddr == TCO_OFS_LEVEL
            |-> prdata == {TCO_PAD_ZERO, $past(chan_out_bit)};
    endproperty
    a_read_level: assert property (p_read_level) // RULE7
        else $error("level read does not show pins");

    property p_collective;
        wr_level && tick_q == TCO_VEC_RST
            |=> ((chan_out_bit ^ $past(wbyte))
                 & ~$past(cfg_q.en)) == TCO_VEC_RST;
    endproperty
    a_collective: assert property (p_collective) // RULE12
        else $error("disabled channel missed collective write");

    // A pending master set may still land on a ticking slave
    property p_enabled_kept;
        wr_level && tick_q == TCO_VEC_RST
            |=> ((chan_out_bit ^ $past(chan_out_bit))
                 & $past(cfg_q.en & (~cfg_q.mode
                 | {TCO_NCH{~count_tick}}))) == TCO_VEC_RST;
    endproperty
    a_enabled_kept: assert property (p_enabled_kept) // RULE5
        else $error("enabled channel took software write");

    property p_start_irq;
        (chan_start_trigger & chan_intcap_mode & cfg_q.sel)
            != TCO_VEC_RST
        |=> (master_tick_irq & $past(chan_start_trigger
            & chan_intcap_mode & cfg_q.sel))
            == $past(chan_start_trigger & chan_intcap_mode
            & cfg_q.sel);
    endproperty
    a_start_irq: assert property (p_start_irq) // RULE13
        else $error("start interrupt missing");

    property p_no_start_irq;
        ##1 (master_tick_irq & $past(chan_start_trigger
            & ~(chan_intcap_mode & cfg_q.sel)
            & ~chan_cycle_end)) == TCO_VEC_RST;
    endproperty
    a_no_start_irq: assert property (p_no_start_irq) // RULE14
        else $error("interrupt at count start not allowed");

    property p_reset_clear;
        sys_rst |=> cfg_q == TCO_CFG_RST
            && chan_out_bit == TCO_VEC_RST && !irq;
    endproperty
    a_reset_clear: assert property (disable iff (1'b0)
        p_reset_clear) // RULE18
        else $error("reset did not clear state");

    property p_irq_level;
        ##1 irq == |(istat_q & imask_q)
            && ((istat_q & $past(tick_q)) == $past(tick_q));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt status lost an event");

    // Disabled pins move only on a level write
    property p_disabled_hold;
        !wr_level |=> ((chan_out_bit ^ $past(chan_out_bit))
            & ~$past(cfg_q.en)) == TCO_VEC_RST;
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) // RULE6
        else $error("disabled pin moved without a write");

    property p_pol_quiet;
        wr_pol && tick_q == TCO_VEC_RST && !count_tick
            |=> $stable(chan_out_bit);
    endproperty
    a_pol_quiet: assert property (p_pol_quiet) // RULE10
        else $error("polarity write moved a pin");

    property p_err_resp;
        access && !hit |-> pslverr && prdata == TCO_WORD_ZERO;
    endproperty
    a_err_resp: assert property (p_err_resp)
        else $error("unmapped access not refused");

    property p_mask_write;
        wr_imask |=> imask_q == $past(wbyte);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write lost");

    property p_w1c;
        wr_istat && tick_q == TCO_VEC_RST
            |=> (istat_q & $past(wbyte)) == TCO_VEC_RST;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("status bit not cleared");

    property p_en_write;
        wr_enable |=> cfg_q.en == $past(wbyte);
    endproperty
    a_en_write: assert property (p_en_write) // RULE5
        else $error("enable write lost");

    property p_mode_write;
        wr_mode |=> cfg_q.mode == $past(wbyte);
    endproperty
    a_mode_write: assert property (p_mode_write) // RULE2
        else $error("mode write lost");

    property p_sel_write;
        wr_stsel |=> cfg_q.sel == $past(wbyte);
    endproperty
    a_sel_write: assert property (p_sel_write) // RULE13
        else $error("start select write lost");

    property p_cov_slave;
        |(cfg_q.en & cfg_q.mode) ##1 $rose(|chan_out_bit);
    endproperty
    c_slave: cover property (p_cov_slave);

    property p_cov_coll;
        wr_level && cfg_q.en != TCO_VEC_RST
            && ~cfg_q.en != TCO_VEC_RST;
    endproperty
    c_coll: cover property (p_cov_coll);

    property p_cov_irq;
        $rose(irq);
    endproperty
    c_irq: cover property (p_cov_irq);
endmodule // tco_output_ctrl

// file: sim/tco_counter_model.sv
// Behavioural model of the counter channels that feed the output stage
`timescale 1ns/100ps
module tco_counter_model #(
    parameter int RELOAD = 3
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // Requests from the bench
    input  wire tco_pkg::tco_chan_vec_t req_end,
    input  wire tco_pkg::tco_chan_vec_t req_start,
    input  wire tco_pkg::tco_chan_vec_t run,
    input  wire logic                   tick_free,
    input  wire logic                   tick_req,
    // Towards the output stage
    output tco_pkg::tco_chan_vec_t      chan_cycle_end,
    output tco_pkg::tco_chan_vec_t      chan_start_trigger,
    output logic                        count_tick
);
    import tco_pkg::*;
    int            cnt_q [TCO_NCH];
    tco_chan_vec_t wrap;

    // Running channels end a cycle when their count runs out
    always_comb begin
        for (int i = 0; i < TCO_NCH; i++) begin
            wrap[i] = run[i] && count_tick && (cnt_q[i] == 0);
        end
    end

    // Registered pulses, so the stage never sees bench-side glitches
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chan_cycle_end     <= TCO_VEC_RST;
            chan_start_trigger <= TCO_VEC_RST;
            count_tick         <= 1'b0;
            for (int i = 0; i < TCO_NCH; i++) begin
                cnt_q[i] <= RELOAD;
            end
        end else begin
            chan_cycle_end     <= req_end | wrap;
            chan_start_trigger <= req_start;
            count_tick         <= tick_free | tick_req;
            for (int i = 0; i < TCO_NCH; i++) begin
                if (run[i] && count_tick) begin
                    cnt_q[i] <= (cnt_q[i] == 0) ? RELOAD : cnt_q[i] - 1;
                end
            end
        end
    end
endmodule // tco_counter_model

// file: sim/tb.sv
// Self-checking bench for the timer channel output stage
`timescale 1ns/100ps
module tb;
    import tco_pkg::*;
    logic          clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic          count_tick, irq, tick_free, tick_req, er;
    tco_addr_t     paddr;
    tco_word_t     pwdata, prdata, rd;
    tco_chan_vec_t chan_cycle_end, chan_start_trigger, chan_intcap_mode;
    tco_chan_vec_t master_tick_irq, chan_out_bit, req_end, req_start, run;
    tco_chan_vec_t exp_pin, exp_st, en, sel, mode, pol, ev, s, w;
    int            mismatches, n_checks, hi;

    tco_output_ctrl u_tco_output_ctrl (
        .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .chan_cycle_end, .chan_start_trigger,
        .chan_intcap_mode, .count_tick, .master_tick_irq, .chan_out_bit, .irq
    );
    tco_counter_model u_tco_counter_model (
        .clock, .sys_rst, .req_end, .req_start, .run, .tick_free, .tick_req,
        .chan_cycle_end, .chan_start_trigger, .count_tick
    );

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic miss(input string m);
        mismatches++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask

    task automatic chk8(input tco_chan_vec_t g, input tco_chan_vec_t e);
        n_checks++;
        if (g !== e) miss($sformatf("pins %h expected %h", g, e));
    endtask

    task automatic chkw(input tco_word_t g, input tco_word_t e);
        n_checks++;
        if (g !== e) miss($sformatf("word %h expected %h", g, e));
    endtask

    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) miss($sformatf("flag %b expected %b", g, e));
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic is_wr, input tco_addr_t a,
                       input tco_word_t d);
        int n;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= is_wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miss("bus timeout");
            tally_and_finish();
        end
    endtask

    task automatic wr(input tco_addr_t a, input tco_chan_vec_t d);
        apb(1'b1, a, {TCO_PAD_ZERO, d});
    endtask

    task automatic rdw(input tco_addr_t a);
        apb(1'b0, a, TCO_WORD_ZERO);
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    // Counter events, then time for the delayed set to land
    task automatic fire(input tco_chan_vec_t e, input tco_chan_vec_t st);
        req_end   <= e;
        req_start <= st;
        @(posedge clock);
        req_end   <= '0;
        req_start <= '0;
        @(posedge clock);
        #1;
        chk8(master_tick_irq, e | (st & chan_intcap_mode & sel));
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Pin levels after one burst; a master's delayed set lands last
    function automatic tco_chan_vec_t ref_pin(tco_chan_vec_t c,
                                              tco_chan_vec_t e);
        int m;
        for (int i = 0; i < TCO_NCH; i++) begin
            m = (i % 2 == 1) ? i - 1 : i - 2;
            if (!en[i]) continue;
            if (mode[i] == TCO_MODE_MASTER) begin
                if (e[i]) c[i] = ~c[i];
            end else begin
                if (e[i]) c[i] = pol[i];
                if (m >= 0 && e[m]) c[i] = ~pol[i];
            end
        end
        return c;
    endfunction

    initial begin
        {psel, penable, pwrite, tick_req} = '0;
        {paddr, pwdata, req_end, req_start, run, chan_intcap_mode} = '0;
        {exp_pin, exp_st, en, sel} = '0;
        tick_free  = 1'b1;
        sys_rst    = 1'b1;
        mismatches = 0;
        n_checks   = 0;
        hi = $urandom(32'h06961876);
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) begin
            rdw(tco_addr_t'(a));
            chkw(rd, TCO_WORD_ZERO);
        end
        chk8(chan_out_bit, TCO_VEC_RST);
        rdw(8'h1C);
        chk1(er, 1'b1);
        done("reset");
        // Delayed master event meets own event on slave channel 1; reset wins for either polarity
        for (int p = 0; p < 2; p++) begin
            wr(TCO_OFS_ENABLE, 8'h00);
            wr(TCO_OFS_MODE, 8'h02);
            wr(TCO_OFS_POL, (p == 1) ? 8'h02 : 8'h00);
            wr(TCO_OFS_LEVEL, 8'h02);
            wr(TCO_OFS_ENABLE, 8'h02);
            req_end <= 8'h01;
            @(posedge clock);
            req_end <= 8'h02;
            @(posedge clock);
            req_end <= 8'h00;
            repeat (8) @(posedge clock);
            #1;
            chk1(chan_out_bit[1], 1'b0);
        end
        done("reset_wins");
        // Master set or reset on slave channel 3 waits for a count clock
        tick_free <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            wr(TCO_OFS_ENABLE, 8'h00);
            wr(TCO_OFS_MODE, 8'h08);
            wr(TCO_OFS_POL, (p == 1) ? 8'h08 : 8'h00);
            wr(TCO_OFS_LEVEL, (p == 1) ? 8'h08 : 8'h00);
            wr(TCO_OFS_ENABLE, 8'h08);
            fire(8'h04, 8'h00);
            chk1(chan_out_bit[3], p[0]);
            @(posedge clock);
            tick_req <= 1'b1;
            @(posedge clock);
            tick_req <= 1'b0;
            repeat (4) @(posedge clock);
            #1;
            chk1(chan_out_bit[3], ~p[0]);
        end
        tick_free <= 1'b1;
        done("delayed_set");
        // Toggle output on a free-running channel
        wr(TCO_OFS_ENABLE, 8'h00);
        wr(TCO_OFS_MODE, 8'h00);
        wr(TCO_OFS_LEVEL, 8'h00);
        wr(TCO_OFS_ENABLE, 8'h01);
        run <= 8'h01;
        repeat (12) @(posedge clock);
        hi = 0;
        repeat (64) begin
            @(posedge clock);
            hi += chan_out_bit[0];
        end
        run <= '0;
        chkw(tco_word_t'(hi), 32'h0000_0020);
        done("square_wave");
        // Quiet start for the random phase
        wr(TCO_OFS_ENABLE, 8'h00);
        wr(TCO_OFS_LEVEL, 8'h00);
        wr(TCO_OFS_ISTAT, 8'hFF);
        for (int it = 0; it < 40; it++) begin
            mode = tco_chan_vec_t'($urandom);
            pol  = tco_chan_vec_t'($urandom);
            sel  = tco_chan_vec_t'($urandom);
            w    = tco_chan_vec_t'($urandom);
            wr(TCO_OFS_MODE, mode);
            wr(TCO_OFS_POL, pol);
            wr(TCO_OFS_STSEL, sel);
            chk8(chan_out_bit, exp_pin);
            wr(TCO_OFS_LEVEL, w);
            exp_pin = (exp_pin & en) | (w & ~en);
            rdw(TCO_OFS_LEVEL);
            chkw(rd, {TCO_PAD_ZERO, exp_pin});
            en = tco_chan_vec_t'($urandom);
            wr(TCO_OFS_ENABLE, en);
            chan_intcap_mode <= tco_chan_vec_t'($urandom);
            ev = tco_chan_vec_t'($urandom & $urandom);
            s  = tco_chan_vec_t'($urandom);
            fire(ev, s);
            ev = ev | (s & chan_intcap_mode & sel);
            exp_pin = ref_pin(exp_pin, ev);
            chk8(chan_out_bit, exp_pin);
            exp_st = exp_st | ev;
            rdw(TCO_OFS_ISTAT);
            chkw(rd, {TCO_PAD_ZERO, exp_st});
            w = tco_chan_vec_t'($urandom);
            wr(TCO_OFS_IMASK, w);
            #1;
            chk1(irq, |(exp_st & w));
            s = tco_chan_vec_t'($urandom);
            wr(TCO_OFS_ISTAT, s);
            exp_st = exp_st & ~s;
            #1;
            chk1(irq, |(exp_st & w));
        end
        done("random");
        tally_and_finish();
    end
endmodule // tb
